// ==== hw/tpw_top.sv ====
// Purpose: Time clock counter, watchdog and counter clock selection behind APB
// Assumes: Clock ticks and pins arrive synchronous to clock, one cycle wide
// Notes:   Zero-wait APB slave; register byte address is four times its index
`timescale 1ns/1ps
`include "tpw_map.svh"
module tpw_top (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               sub_oscillator_clock,
  input  wire logic               main_oscillator_clock,
  input  wire logic               instruction_tick,
  input  wire logic               time_counter_pin,
  input  wire logic               watchdog_clear_instruction,
  input  wire logic               sleep_instruction,
  input  wire tpw_pkg::tpw_mode_t mode,
  output logic                    watchdog_reset,
  output logic                    watchdog_wake,
  output logic      [3:0]         counter_underflow
);
  function automatic logic [5:0] reg_index(input logic [7:0] addr);
    reg_index = addr[7:2];
  endfunction : reg_index

  logic [7:0]  watchdog_control_reg;
  logic [7:0]  counter_pair_clock_control_reg;
  logic [7:0]  pulse_width_timer_clock_control_reg;
  logic [7:0]  time_counter_control_reg;
  logic [7:0]  time_clock_counter_reg;
  logic [7:0]  time_clock_counter_next;
  logic [7:0]  run_control_reg;
  logic [7:0]  preset_reg [4];
  logic [7:0]  watchdog_count_reg;
  logic [7:0]  watchdog_count_next;
  logic        watchdog_half_reg;
  logic        pin_prev_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic        watchdog_reset_reg;
  logic        watchdog_wake_reg;
  logic [3:0]  counter_underflow_reg;

  // Bus decode
  logic        setup_phase;
  logic        write_fire;
  logic        byte_write;
  logic [5:0]  setup_idx;
  logic [5:0]  fire_idx;
  logic [7:0]  wbyte;
  logic        setup_mapped;
  logic [7:0]  read_byte;

  assign setup_phase = psel & ~penable & ~pready_reg;
  assign write_fire  = psel & penable & pready_reg & pwrite & ~pslverr_reg;
  assign byte_write  = write_fire & pstrb[0];
  assign setup_idx   = reg_index(paddr);
  assign fire_idx    = reg_index(paddr);
  assign wbyte       = pwdata[7:0];

  logic wr_time_counter;
  logic wr_time_ctrl;
  logic wr_watchdog_ctrl;
  logic wr_pair_ctrl;
  logic wr_pulse_ctrl;
  logic wr_run_ctrl;

  assign wr_time_counter  = byte_write & (fire_idx == `TPW_IDX_TIME_COUNTER);
  assign wr_time_ctrl     = byte_write & (fire_idx == `TPW_IDX_TIME_CTRL);
  assign wr_watchdog_ctrl = byte_write & (fire_idx == `TPW_IDX_WATCHDOG_CTRL);
  assign wr_pair_ctrl     = byte_write & (fire_idx == `TPW_IDX_COUNTER_PAIR_CTRL);
  assign wr_pulse_ctrl    = byte_write & (fire_idx == `TPW_IDX_PULSE_CTRL);
  assign wr_run_ctrl      = byte_write & (fire_idx == `TPW_IDX_RUN_CTRL);

  // Per-counter clock select, ratio, preset write and live count
  logic [3:0]  cnt_sel;
  logic [2:0]  cnt_ratio [4];
  logic [3:0]  cnt_src_tick;
  logic [3:0]  cnt_tick;
  logic [3:0]  cnt_load;
  logic [3:0]  cnt_uf;
  logic [3:0]  run_prev_reg;
  logic [7:0]  cnt_value [4];

  assign cnt_sel[0]   = counter_pair_clock_control_reg[`TPW_LO_SEL_BIT];
  assign cnt_ratio[0] = counter_pair_clock_control_reg[`TPW_LO_RATIO_MSB:`TPW_LO_RATIO_LSB];
  assign cnt_sel[1]   = counter_pair_clock_control_reg[`TPW_HI_SEL_BIT];
  assign cnt_ratio[1] = counter_pair_clock_control_reg[`TPW_HI_RATIO_MSB:`TPW_HI_RATIO_LSB];
  assign cnt_sel[2]   = pulse_width_timer_clock_control_reg[`TPW_LO_SEL_BIT];
  assign cnt_ratio[2] =
    pulse_width_timer_clock_control_reg[`TPW_LO_RATIO_MSB:`TPW_LO_RATIO_LSB];
  assign cnt_sel[3]   = pulse_width_timer_clock_control_reg[`TPW_HI_SEL_BIT];
  assign cnt_ratio[3] =
    pulse_width_timer_clock_control_reg[`TPW_HI_RATIO_MSB:`TPW_HI_RATIO_LSB];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_counter
      assign cnt_src_tick[gi] = cnt_sel[gi] ? main_oscillator_clock : sub_oscillator_clock;
      // Starting a counter loads its preset so the first period is full
      assign cnt_load[gi] = (byte_write & (fire_idx == `TPW_IDX_PRESET_BASE + 6'(gi))) |
                            (run_control_reg[gi] & ~run_prev_reg[gi]);
      tpw_prescaler #(.OFFSET(`TPW_RATIO_BASE_TWO)) u_psc (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .tick_in  (cnt_src_tick[gi]),
        .clear    (cnt_load[gi]),
        .bypass   (1'b0),
        .ratio    (cnt_ratio[gi]),
        .tick_out (cnt_tick[gi]),
        .count    ()
      );
      tpw_down_counter u_cnt (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .tick      (cnt_tick[gi]),
        .run       (run_control_reg[gi]),
        .load      (cnt_load[gi]),
        .preset    (preset_reg[gi]),
        .count     (cnt_value[gi]),
        .underflow (cnt_uf[gi])
      );
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          preset_reg[gi] <= `TPW_BYTE_ZERO;
        end else if (byte_write & (fire_idx == `TPW_IDX_PRESET_BASE + 6'(gi))) begin
          preset_reg[gi] <= wbyte;
        end
      end
    end
  endgenerate

  // Time clock counter: source, edge and its own prescaler
  logic       tc_source_pin;
  logic       tc_falling;
  logic       pin_edge;
  logic       tc_raw_tick;
  logic       tc_tick;
  logic [7:0] tc_psc_count;

  assign tc_source_pin = time_counter_control_reg[`TPW_TC_SRC_BIT];
  assign tc_falling    = time_counter_control_reg[`TPW_TC_EDGE_BIT];
  assign pin_edge      = tc_falling ? (pin_prev_reg & ~time_counter_pin) :
                                      (~pin_prev_reg & time_counter_pin);
  assign tc_raw_tick   = tc_source_pin ? pin_edge : instruction_tick;

  tpw_prescaler #(.OFFSET(`TPW_RATIO_BASE_TWO)) u_tc_psc (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .tick_in  (tc_raw_tick),
    .clear    (wr_time_counter),
    .bypass   (~time_counter_control_reg[`TPW_TC_PSC_EN_BIT]),
    .ratio    (time_counter_control_reg[`TPW_TC_RATIO_MSB:0]),
    .tick_out (tc_tick),
    .count    (tc_psc_count)
  );

  assign time_clock_counter_next = wr_time_counter ? wbyte :
                                   tc_tick ? time_clock_counter_reg + `TPW_BYTE_ONE :
                                   time_clock_counter_reg;

  // Watchdog: sub-oscillator halved, prescaled, then 256 ticks to timeout
  logic       wd_enable;
  logic       wd_clear;
  logic       wd_half_tick;
  logic       wd_tick;
  logic       wd_timeout;
  logic       wd_reset_mode;
  logic [7:0] wd_psc_count;

  assign wd_enable     = watchdog_control_reg[`TPW_WD_EN_BIT];
  assign wd_clear      = watchdog_clear_instruction | sleep_instruction | ~wd_enable;
  assign wd_half_tick  = sub_oscillator_clock & watchdog_half_reg & wd_enable;
  assign wd_timeout    = wd_tick & (watchdog_count_reg == `TPW_BYTE_MAX);
  assign wd_reset_mode = (mode != tpw_pkg::TPW_MODE_SLEEP);
  assign watchdog_count_next = wd_clear ? `TPW_BYTE_ZERO :
                               wd_tick ? watchdog_count_reg + `TPW_BYTE_ONE :
                               watchdog_count_reg;

  tpw_prescaler #(.OFFSET(`TPW_RATIO_BASE_ONE)) u_wd_psc (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .tick_in  (wd_half_tick),
    .clear    (wd_clear),
    .bypass   (1'b0),
    .ratio    (watchdog_control_reg[`TPW_WD_RATIO_MSB:0]),
    .tick_out (wd_tick),
    .count    (wd_psc_count)
  );

  // Read mux
  logic       idx_preset;
  logic       idx_count;
  logic [1:0] sub_idx;

  assign idx_preset = (setup_idx >= `TPW_IDX_PRESET_BASE) & (setup_idx <= `TPW_IDX_PRESET_LAST);
  assign idx_count  = (setup_idx >= `TPW_IDX_COUNT_BASE) & (setup_idx <= `TPW_IDX_COUNT_LAST);
  assign sub_idx    = idx_preset ? 2'(setup_idx - `TPW_IDX_PRESET_BASE) :
                                   2'(setup_idx - `TPW_IDX_COUNT_BASE);

  always_comb begin
    read_byte    = `TPW_BYTE_ZERO;
    setup_mapped = 1'b1;
    if (setup_idx == `TPW_IDX_TIME_COUNTER) begin
      read_byte = time_clock_counter_reg;
    end else if (setup_idx == `TPW_IDX_TIME_CTRL) begin
      read_byte = time_counter_control_reg;
    end else if (setup_idx == `TPW_IDX_WATCHDOG_CTRL) begin
      read_byte = watchdog_control_reg;
    end else if (setup_idx == `TPW_IDX_COUNTER_PAIR_CTRL) begin
      read_byte = counter_pair_clock_control_reg;
    end else if (setup_idx == `TPW_IDX_PULSE_CTRL) begin
      read_byte = pulse_width_timer_clock_control_reg;
    end else if (setup_idx == `TPW_IDX_RUN_CTRL) begin
      read_byte = run_control_reg;
    end else if (setup_idx == `TPW_IDX_WATCHDOG_COUNT) begin
      read_byte = watchdog_count_reg;
    end else if (idx_preset) begin
      read_byte = preset_reg[sub_idx];
    end else if (idx_count) begin
      read_byte = cnt_value[sub_idx];
    end else begin
      setup_mapped = 1'b0;
    end
  end

  // Bus and control registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end else begin
      pready_reg  <= setup_phase;
      pslverr_reg <= setup_phase & ~setup_mapped;
      prdata_reg  <= setup_phase & ~pwrite ? {24'h000000, read_byte} : 32'h00000000;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      watchdog_control_reg                <= `TPW_BYTE_ZERO;
      counter_pair_clock_control_reg      <= `TPW_BYTE_ZERO;
      pulse_width_timer_clock_control_reg <= `TPW_BYTE_ZERO;
      time_counter_control_reg            <= `TPW_TC_CTRL_RESET;
      run_control_reg                     <= `TPW_BYTE_ZERO;
    end else begin
      if (wr_watchdog_ctrl) watchdog_control_reg <= wbyte & `TPW_WD_CTRL_MASK;
      if (wr_pair_ctrl) counter_pair_clock_control_reg <= wbyte;
      if (wr_pulse_ctrl) pulse_width_timer_clock_control_reg <= wbyte;
      if (wr_time_ctrl) time_counter_control_reg <= wbyte & `TPW_TC_CTRL_MASK;
      if (wr_run_ctrl) run_control_reg <= wbyte & `TPW_RUN_MASK;
    end
  end

  // Counting state and registered outputs
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      time_clock_counter_reg <= `TPW_BYTE_ZERO;
      watchdog_count_reg     <= `TPW_BYTE_ZERO;
      watchdog_half_reg      <= 1'b0;
      pin_prev_reg           <= 1'b0;
      run_prev_reg           <= 4'h0;
      watchdog_reset_reg     <= 1'b0;
      watchdog_wake_reg      <= 1'b0;
      counter_underflow_reg  <= 4'h0;
    end else begin
      time_clock_counter_reg <= time_clock_counter_next;
      watchdog_count_reg     <= watchdog_count_next;
      watchdog_half_reg      <= wd_clear ? 1'b0 : watchdog_half_reg ^ sub_oscillator_clock;
      pin_prev_reg           <= time_counter_pin;
      run_prev_reg           <= run_control_reg[3:0];
      watchdog_reset_reg     <= wd_timeout & wd_enable & wd_reset_mode;
      watchdog_wake_reg      <= wd_timeout & wd_enable & ~wd_reset_mode;
      counter_underflow_reg  <= cnt_uf;
    end
  end

  assign prdata            = prdata_reg;
  assign pready            = pready_reg;
  assign pslverr           = pslverr_reg;
  assign watchdog_reset    = watchdog_reset_reg;
  assign watchdog_wake     = watchdog_wake_reg;
  assign counter_underflow = counter_underflow_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_WD_DISABLED_QUIET: assert property (
    !wd_enable |=> !watchdog_reset && !watchdog_wake)
    else $error("watchdog fired while disabled");
  AST_TC_INSTR_INC: assert property (
    !tc_source_pin && !time_counter_control_reg[`TPW_TC_PSC_EN_BIT] && instruction_tick
    && !wr_time_counter |=> time_clock_counter_reg == $past(time_clock_counter_reg) + 8'h01)
    else $error("time counter missed an instruction cycle");
  AST_TC_PIN_RISE: assert property (
    tc_source_pin && !tc_falling && !time_counter_control_reg[`TPW_TC_PSC_EN_BIT]
    && !pin_prev_reg && time_counter_pin && !wr_time_counter
    |=> time_clock_counter_reg == $past(time_clock_counter_reg) + 8'h01)
    else $error("time counter missed a rising pin edge");
  AST_TC_WRITE_CLEARS: assert property (
    wr_time_counter |=> tc_psc_count == 8'h00 && time_clock_counter_reg == $past(wbyte))
    else $error("time counter write did not clear prescaler");
  AST_WD_INSTR_CLEARS: assert property (
    watchdog_clear_instruction || sleep_instruction
    |=> wd_psc_count == 8'h00 && watchdog_count_reg == 8'h00)
    else $error("watchdog clear did not restart the chain");
  AST_WD_SUB_ONLY: assert property (
    !sub_oscillator_clock |=> $stable(wd_psc_count) || wd_psc_count == 8'h00)
    else $error("watchdog chain moved without a sub-oscillator tick");
  AST_WD_RESET_MODE: assert property (
    wd_timeout && wd_enable && mode != tpw_pkg::TPW_MODE_SLEEP |=> watchdog_reset ##1 !watchdog_reset)
    else $error("watchdog timeout did not reset the device");
  AST_WD_SLEEP_NO_RESET: assert property (
    mode == tpw_pkg::TPW_MODE_SLEEP |=> !watchdog_reset)
    else $error("watchdog reset raised in sleep");
  AST_CNT_RELOAD: assert property (
    counter_underflow[0] |-> cnt_value[0] == preset_reg[0] || $past(cnt_load[0]))
    else $error("counter one did not reload its preset");
  AST_APB_ZERO_WAIT: assert property (
    psel && !penable && !pready |=> pready ##1 !pready)
    else $error("slave did not answer in the access cycle");

endmodule : tpw_top

// ==== include/tpw_map.svh ====
// Purpose: Register indexes, field positions and reset values of the timer block
// Assumes: APB byte address is four times the register index
// Notes:   Definitions only
`ifndef TPW_MAP_SVH
`define TPW_MAP_SVH

`define TPW_IDX_TIME_COUNTER      6'h01
`define TPW_IDX_TIME_CTRL         6'h07
`define TPW_IDX_WATCHDOG_CTRL     6'h08
`define TPW_IDX_COUNTER_PAIR_CTRL 6'h09
`define TPW_IDX_PULSE_CTRL        6'h0A
`define TPW_IDX_PRESET_BASE       6'h0B
`define TPW_IDX_PRESET_LAST       6'h0E
`define TPW_IDX_RUN_CTRL          6'h11
`define TPW_IDX_WATCHDOG_COUNT    6'h12
`define TPW_IDX_COUNT_BASE        6'h13
`define TPW_IDX_COUNT_LAST        6'h16

`define TPW_WD_EN_BIT             3
`define TPW_WD_RATIO_MSB          2
`define TPW_TC_SRC_BIT            5
`define TPW_TC_EDGE_BIT           4
`define TPW_TC_PSC_EN_BIT         3
`define TPW_TC_RATIO_MSB          2
`define TPW_LO_SEL_BIT            3
`define TPW_HI_SEL_BIT            7
`define TPW_LO_RATIO_MSB          2
`define TPW_LO_RATIO_LSB          0
`define TPW_HI_RATIO_MSB          6
`define TPW_HI_RATIO_LSB          4

`define TPW_TC_CTRL_RESET         8'h3F
`define TPW_TC_CTRL_MASK          8'h3F
`define TPW_WD_CTRL_MASK          8'h0F
`define TPW_RUN_MASK              8'h0F
`define TPW_BYTE_ZERO             8'h00
`define TPW_BYTE_ONE              8'h01
`define TPW_BYTE_MAX              8'hFF
`define TPW_RATIO_BASE_ONE        3'h0
`define TPW_RATIO_BASE_TWO        3'h1

`endif

// ==== include/tpw_pkg.sv ====
// Purpose: Shared types of the timer block
// Assumes: Nothing
// Notes:   Operating mode is driven by the core's power controller
package tpw_pkg;

  typedef enum logic [1:0] {
    TPW_MODE_NORMAL = 2'b00,
    TPW_MODE_GREEN  = 2'b01,
    TPW_MODE_IDLE   = 2'b10,
    TPW_MODE_SLEEP  = 2'b11
  } tpw_mode_t;

endpackage : tpw_pkg

// ==== hw/tpw_prescaler.sv ====
// Purpose: 8-bit synchronous prescaler with power-of-two ratio select
// Assumes: tick_in is a one-cycle enable pulse
// Notes:   Ratio is 2^(ratio+OFFSET); clear wins over a tick in count, not in tick_out
`timescale 1ns/1ps
`include "tpw_map.svh"
module tpw_prescaler #(
  parameter logic [2:0] OFFSET = `TPW_RATIO_BASE_ONE
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       tick_in,
  input  wire logic       clear,
  input  wire logic       bypass,
  input  wire logic [2:0] ratio,
  output logic            tick_out,
  output logic      [7:0] count
);
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [3:0] shift_amt;
  logic [8:0] mask_wide;
  logic [7:0] mask;

  assign shift_amt  = {1'b0, ratio} + {1'b0, OFFSET};
  assign mask_wide  = (9'h001 << shift_amt) - 9'h001;
  assign mask       = mask_wide[7:0];
  assign tick_out   = tick_in & (bypass | ((count_reg & mask) == mask));
  assign count_next = clear ? `TPW_BYTE_ZERO :
                      tick_in ? count_reg + `TPW_BYTE_ONE : count_reg;
  assign count      = count_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_reg <= `TPW_BYTE_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : tpw_prescaler

// ==== hw/tpw_down_counter.sv ====
// Purpose: 8-bit down counter with automatic preset reload
// Assumes: tick is a one-cycle enable pulse
// Notes:   load takes priority over counting
`timescale 1ns/1ps
`include "tpw_map.svh"
module tpw_down_counter (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       tick,
  input  wire logic       run,
  input  wire logic       load,
  input  wire logic [7:0] preset,
  output logic      [7:0] count,
  output logic            underflow
);
  logic [7:0] count_reg;
  logic [7:0] count_next;

  assign underflow  = run & tick & ~load & (count_reg == `TPW_BYTE_ZERO);
  assign count_next = load ? preset :
                      underflow ? preset :
                      (run & tick) ? count_reg - `TPW_BYTE_ONE : count_reg;
  assign count      = count_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_reg <= `TPW_BYTE_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : tpw_down_counter

// ==== tb/tpw_top_tb.sv ====
// Purpose: Register, time counter, watchdog and down-counter checks of tpw_top
// Assumes: Zero-wait APB; tick inputs held high act as a tick every cycle
// Notes:   Watchdog timing is checked to one cycle of output latency
`timescale 1ns/1ps
module tpw_top_tb;
  logic               clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0, prdata;
  logic [3:0]         pstrb = 4'hF, counter_underflow;
  logic               pready, pslverr, watchdog_reset, watchdog_wake;
  logic               sub_clk = 0, main_clk = 0, itick = 0, pin = 0, wd_clr = 0, sleep_ins = 0;
  tpw_pkg::tpw_mode_t mode = tpw_pkg::TPW_MODE_NORMAL;
  int                 num_errors = 0, n_checks = 0, n;
  logic               w, e;
  logic [31:0]        r;
  tpw_top dut_u (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sub_oscillator_clock(sub_clk),
    .main_oscillator_clock(main_clk), .instruction_tick(itick), .time_counter_pin(pin),
    .watchdog_clear_instruction(wd_clr), .sleep_instruction(sleep_ins), .mode(mode),
    .watchdog_reset(watchdog_reset), .watchdog_wake(watchdog_wake),
    .counter_underflow(counter_underflow));
  initial begin
    forever #50 clock = ~clock;
  end
  task results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  task apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    int t;
    t = 0;
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= {24'h0, d};
    @(posedge clock) penable <= 1;
    do begin @(posedge clock); t++; end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: no ready from slave", $time);
    end
    r = prdata; e = pslverr; psel <= 0; penable <= 0;
    @(posedge clock);
  endtask : apb
  task rd(input logic [5:0] idx, input logic [7:0] x);
    apb(0, idx, 8'h00); chk(r, {24'h0, x}, "read data");
  endtask : rd
  task ticks(input int lim);
    n = 0; w = 0; sub_clk <= 1;
    while (n < lim && w !== 1'b1) begin
      @(posedge clock); n++; w = watchdog_reset | watchdog_wake; e = watchdog_wake;
    end
    @(posedge clock) sub_clk <= 0;
  endtask : ticks
  task wd(input logic [7:0] c, input int x, input logic wake);
    apb(1, 6'h08, 8'h00); apb(1, 6'h08, c); ticks(x + 10);
    chk(n >= x + 1 && n <= x + 2, 1, "watchdog period"); chk(e, wake, "wake");
  endtask : wd
  task per(input int b);
    n = 0;
    do @(posedge clock); while (counter_underflow[b] !== 1'b1 && ++n < 2000);
    n = 0;
    do begin @(posedge clock); n++; end while (counter_underflow[b] !== 1'b1 && n < 2000);
  endtask : per
  task pulses(input int k, input logic t);
    repeat (k) begin
      @(posedge clock) begin itick <= 1; pin <= ~t; end
      @(posedge clock) pin <= t;
      itick <= 0;
    end
  endtask : pulses
  initial begin
    #1500000 num_errors++;
    results();
  end
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 0;
    rd(6'h07, 8'h3F); rd(6'h08, 8'h00); rd(6'h09, 8'h00); rd(6'h0A, 8'h00);
    apb(1, 6'h08, 8'hFF); rd(6'h08, 8'h0F);
    apb(1, 6'h09, 8'hA5); rd(6'h09, 8'hA5);
    // A write without byte lane zero completes but leaves the register alone
    pstrb <= 4'hE; apb(1, 6'h09, 8'h00); pstrb <= 4'hF; rd(6'h09, 8'hA5);
    apb(1, 6'h0A, 8'h5A); rd(6'h0A, 8'h5A);
    apb(0, 6'h3F, 8'h00); chk(r, 0, "unmapped data"); chk(e, 1, "unmapped error");
    // Each pulse pair gives one instruction tick and one pin rise
    apb(1, 6'h07, 8'h00); apb(1, 6'h01, 8'h10); pulses(5, 0); rd(6'h01, 8'h15);
    apb(1, 6'h07, 8'h08); apb(1, 6'h01, 8'h00); pulses(7, 0); rd(6'h01, 8'h03);
    apb(1, 6'h07, 8'h0F); apb(1, 6'h01, 8'h00); pulses(255, 0); rd(6'h01, 8'h00);
    pulses(1, 0); rd(6'h01, 8'h01);
    apb(1, 6'h07, 8'h20); apb(1, 6'h01, 8'h00); pulses(3, 0); rd(6'h01, 8'h03);
    apb(1, 6'h07, 8'h30); apb(1, 6'h01, 8'h00); pulses(3, 1); rd(6'h01, 8'h02);
    wd(8'h08, 512, 0);
    wd(8'h09, 1024, 0);
    apb(1, 6'h08, 8'h00); apb(1, 6'h08, 8'h08); ticks(300);
    // 301 sub ticks halved give 150 prescaled ticks
    rd(6'h12, 8'h96);
    @(posedge clock) wd_clr <= 1;
    @(posedge clock) wd_clr <= 0;
    ticks(600); chk(n >= 513 && n <= 514, 1, "after clear");
    mode <= tpw_pkg::TPW_MODE_GREEN; ticks(300);
    @(posedge clock) sleep_ins <= 1;
    @(posedge clock) sleep_ins <= 0;
    ticks(600); chk(n >= 513 && n <= 514, 1, "after sleep");
    chk(e, 0, "green reset");
    mode <= tpw_pkg::TPW_MODE_IDLE; wd(8'h08, 512, 0);
    mode <= tpw_pkg::TPW_MODE_SLEEP; wd(8'h08, 512, 1);
    apb(1, 6'h08, 8'h00); ticks(1100); chk(n, 1100, "disabled");
    rd(6'h12, 8'h00);
    mode <= tpw_pkg::TPW_MODE_NORMAL;
    apb(1, 6'h09, 8'h18); apb(1, 6'h0B, 8'h02); apb(1, 6'h0C, 8'h01);
    apb(1, 6'h0A, 8'h88); apb(1, 6'h0D, 8'h00); apb(1, 6'h0E, 8'h03);
    apb(1, 6'h11, 8'h0F); rd(6'h11, 8'h0F); main_clk <= 1;
    per(0); chk(n, 6, "counter one period");
    per(2); chk(n, 2, "high pulse period");
    per(3); chk(n, 8, "low pulse period");
    // Main ticks stop so only the sub-oscillator can drive counter two
    main_clk <= 0; sub_clk <= 1; per(1); chk(n, 8, "counter two period");
    results();
  end
endmodule : tpw_top_tb
